// >>> design/gds_pkg.sv
// gds_pkg: register references, field positions and timing constants of the status map
package gds_pkg;
    // register references, 16-bit reference offsets as carried on the read port
    localparam logic [15:0] ADDR_ALARM_ONE   = 16'h2711; // discrete input 10001
    localparam logic [15:0] ADDR_ALARM_TWO   = 16'h2712; // discrete input 10002
    localparam logic [15:0] ADDR_FAULT       = 16'h2713; // discrete input 10003
    localparam logic [15:0] ADDR_MENU        = 16'h2714; // discrete input 10004
    localparam logic [15:0] ADDR_TEST        = 16'h2715; // discrete input 10005
    localparam logic [15:0] ADDR_CAL         = 16'h2716; // discrete input 10006
    localparam logic [15:0] ADDR_RSVD_INPUT  = 16'h2717; // discrete input 10007
    localparam logic [15:0] ADDR_TOGGLE      = 16'h2718; // discrete input 10008
    localparam logic [15:0] ADDR_STATE_TWO   = 16'h9c53; // holding register 40019
    localparam logic [15:0] ADDR_SCALE_ONE   = 16'h9c54; // holding register 40020
    localparam logic [15:0] ADDR_SCALE_TWO   = 16'h9c55; // holding register 40021

    // field positions inside the second state register
    localparam int BIT_ALARM_ONE  = 0;
    localparam int BIT_ALARM_TWO  = 1;
    localparam int BIT_FAULT      = 2;
    localparam int BIT_MAINT      = 3;
    localparam int BIT_TEST       = 4;
    localparam int BIT_CAL        = 5;
    localparam int BIT_CARTRIDGE  = 7;
    localparam int BIT_FLOW_ERR   = 8;
    localparam int BIT_COMM_ERR   = 9;
    localparam int BIT_PYRO_ERR   = 10;

    // reset values
    localparam logic [15:0] RST_READ_DATA = 16'h0000;
    localparam logic        RST_TOGGLE    = 1'b0;

    // timing: toggle half period and clock rate
    localparam int TOGGLE_TIME_S   = 2;
    localparam int CLK_HZ          = 250_000_000;
    localparam int TOGGLE_CYCLES   = TOGGLE_TIME_S * CLK_HZ;
endpackage : gds_pkg

// >>> design/gds_tick_div.sv
// gds_tick_div: divider that pulses one cycle every PERIOD clock cycles
`timescale 1ns/1ps
module gds_tick_div #(
    parameter int PERIOD = 4
) (
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic nrst,
    // one-cycle enable pulse
    output logic      tick
);
    logic [31:0] count;       // cycles since last pulse
    logic [31:0] next_count;  // next count value
    logic        next_tick;   // next pulse value

    // count up and wrap, pulsing on the wrap
    always_comb begin
        if (count == 32'(PERIOD - 1)) begin
            next_count = 32'h0000_0000;
            next_tick  = 1'b1;
        end else begin
            next_count = count + 32'h0000_0001;
            next_tick  = 1'b0;
        end
    end

    // register counter and pulse
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            count <= 32'h0000_0000;
            tick  <= 1'b0;
        end else begin
            count <= next_count;
            tick  <= next_tick;
        end
    end
endmodule : gds_tick_div

// >>> design/gds_status_map.sv
// gds_status_map: status, discrete input and full-scale register map of the detector
`timescale 1ns/1ps
module gds_status_map #(
    parameter int TOGGLE_PERIOD = gds_pkg::TOGGLE_CYCLES  // cycles between toggles
) (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        nrst,
    // detector conditions
    input  wire logic        alarmOne,
    input  wire logic        alarmTwo,
    input  wire logic        faultActive,
    input  wire logic        maintActive,
    input  wire logic        menuEntered,
    input  wire logic        testActive,
    input  wire logic        calActive,
    input  wire logic        cartridgeErr,
    input  wire logic        flowErr,
    input  wire logic        commErr,
    input  wire logic        pyroErr,
    // full-scale setting, floating-point
    input  wire logic [31:0] fullScale,
    // register read port
    input  wire logic        rdEn,
    input  wire logic [15:0] rdAddr,
    output logic      [15:0] rdData,
    output logic             rdValid,
    output logic             rdError,
    // liveness bit as seen at 10008
    output logic             liveToggle
);
    logic        tick2s;        // pulse once per toggle period
    logic        next_toggle;   // next liveness value
    logic [15:0] stateTwo;      // assembled second state register
    logic [15:0] next_rdData;   // next read data
    logic        next_rdValid;  // next read valid
    logic        next_rdError;  // next unmapped flag

    // widen a single bit into a register word
    function automatic logic [15:0] bitWord(input logic b);
        bitWord = {15'h0000, b};
    endfunction : bitWord

    // two-second enable pulse
    gds_tick_div #(
        .PERIOD (TOGGLE_PERIOD)
    ) u_tick (
        .ref_clk (ref_clk),
        .nrst    (nrst),
        .tick    (tick2s)
    );

    // liveness bit inverts on each pulse
    always_comb begin
        next_toggle = liveToggle;
        if (tick2s) begin
            next_toggle = ~liveToggle;
        end
    end

    // register the liveness bit
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            liveToggle <= gds_pkg::RST_TOGGLE;
        end else begin
            liveToggle <= next_toggle;
        end
    end

    // build the second state register, reserved bits read zero
    always_comb begin
        stateTwo = 16'h0000;
        stateTwo[gds_pkg::BIT_ALARM_ONE] = alarmOne;
        stateTwo[gds_pkg::BIT_ALARM_TWO] = alarmTwo;
        stateTwo[gds_pkg::BIT_FAULT]     = faultActive;
        stateTwo[gds_pkg::BIT_MAINT]     = maintActive;
        stateTwo[gds_pkg::BIT_TEST]      = testActive;
        stateTwo[gds_pkg::BIT_CAL]       = calActive;
        stateTwo[gds_pkg::BIT_CARTRIDGE] = cartridgeErr;
        stateTwo[gds_pkg::BIT_FLOW_ERR]  = flowErr;
        stateTwo[gds_pkg::BIT_COMM_ERR]  = commErr;
        stateTwo[gds_pkg::BIT_PYRO_ERR]  = pyroErr;
    end

    // read decode, answered one cycle after the request
    always_comb begin
        next_rdData  = gds_pkg::RST_READ_DATA;
        next_rdValid = rdEn;
        next_rdError = 1'b0;
        if (rdEn) begin
            unique case (rdAddr)
                gds_pkg::ADDR_ALARM_ONE:  next_rdData = bitWord(alarmOne);
                gds_pkg::ADDR_ALARM_TWO:  next_rdData = bitWord(alarmTwo);
                gds_pkg::ADDR_FAULT:      next_rdData = bitWord(faultActive);
                gds_pkg::ADDR_MENU:       next_rdData = bitWord(menuEntered);
                gds_pkg::ADDR_TEST:       next_rdData = bitWord(testActive);
                gds_pkg::ADDR_CAL:        next_rdData = bitWord(calActive);
                gds_pkg::ADDR_RSVD_INPUT: next_rdData = 16'h0000;
                gds_pkg::ADDR_TOGGLE:     next_rdData = bitWord(liveToggle);
                gds_pkg::ADDR_STATE_TWO:  next_rdData = stateTwo;
                gds_pkg::ADDR_SCALE_ONE:  next_rdData = fullScale[31:16];
                gds_pkg::ADDR_SCALE_TWO:  next_rdData = fullScale[15:0];
                // unmapped reference: zero data, error flagged
                default:                  next_rdError = 1'b1;
            endcase
        end
    end

    // register the read answer
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            rdData  <= gds_pkg::RST_READ_DATA;
            rdValid <= 1'b0;
            rdError <= 1'b0;
        end else begin
            rdData  <= next_rdData;
            rdValid <= next_rdValid;
            rdError <= next_rdError;
        end
    end

    // checks on the register map
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    // true for every reference that the map answers; anything else is flagged
    function automatic logic isMapped(input logic [15:0] addr);
        isMapped = addr inside {gds_pkg::ADDR_ALARM_ONE, gds_pkg::ADDR_ALARM_TWO,
                                gds_pkg::ADDR_FAULT, gds_pkg::ADDR_MENU,
                                gds_pkg::ADDR_TEST, gds_pkg::ADDR_CAL,
                                gds_pkg::ADDR_RSVD_INPUT, gds_pkg::ADDR_TOGGLE,
                                gds_pkg::ADDR_STATE_TWO, gds_pkg::ADDR_SCALE_ONE,
                                gds_pkg::ADDR_SCALE_TWO};
    endfunction : isMapped

    // fault bits follow their conditions, reserved bits 15:11 stay clear
    chk_state_faults: assert property (
        rdEn && rdAddr == gds_pkg::ADDR_STATE_TWO |=>
            rdData[10:8] == {$past(pyroErr), $past(commErr), $past(flowErr)}
            && rdData[15:11] == 5'h00)
        else $error("state two fault bits wrong");

    // upper half of the full-scale value at the first word
    chk_scale_one: assert property (
        rdEn && rdAddr == gds_pkg::ADDR_SCALE_ONE |=>
            rdValid && rdData == $past(fullScale[31:16]))
        else $error("full-scale word one wrong");

    // lower half of the full-scale value at the second word
    chk_scale_two: assert property (
        rdEn && rdAddr == gds_pkg::ADDR_SCALE_TWO |=>
            rdValid && rdData == $past(fullScale[15:0]))
        else $error("full-scale word two wrong");

    // menu input mirrors the menu condition
    chk_menu_input: assert property (
        rdEn && rdAddr == gds_pkg::ADDR_MENU |=> rdData == {15'h0000, $past(menuEntered)})
        else $error("menu input wrong");

    // test input mirrors the test condition
    chk_test_input: assert property (
        rdEn && rdAddr == gds_pkg::ADDR_TEST |=> rdData == {15'h0000, $past(testActive)})
        else $error("test input wrong");

    // calibration input mirrors the calibration condition
    chk_cal_input: assert property (
        rdEn && rdAddr == gds_pkg::ADDR_CAL |=> rdData == {15'h0000, $past(calActive)})
        else $error("calibration input wrong");

    // reserved input is answered and reads zero
    chk_reserved_input: assert property (
        rdEn && rdAddr == gds_pkg::ADDR_RSVD_INPUT |=> rdData == 16'h0000 && !rdError)
        else $error("reserved input not zero");

    // every divider pulse inverts the liveness bit
    chk_toggle_flip: assert property (
        tick2s |=> liveToggle != $past(liveToggle))
        else $error("toggle did not invert");

    // without a pulse the liveness bit holds
    chk_toggle_hold: assert property (
        !tick2s |=> $stable(liveToggle))
        else $error("toggle changed without pulse");

    // the liveness input returns the bit as it stood at the request
    chk_toggle_input: assert property (
        rdEn && rdAddr == gds_pkg::ADDR_TOGGLE |=> rdData == {15'h0000, $past(liveToggle)})
        else $error("toggle input wrong");

    // first alarm input mirrors the first alarm condition
    chk_alarm_mirror: assert property (
        rdEn && rdAddr == gds_pkg::ADDR_ALARM_ONE |=>
            rdData == {15'h0000, $past(alarmOne)} && !rdError)
        else $error("alarm one input mismatch");

    // second alarm input mirrors the second alarm condition
    chk_alarm_two: assert property (
        rdEn && rdAddr == gds_pkg::ADDR_ALARM_TWO |=> rdData == {15'h0000, $past(alarmTwo)})
        else $error("alarm two input mismatch");

    // fault input mirrors the fault condition
    chk_fault_mirror: assert property (
        rdEn && rdAddr == gds_pkg::ADDR_FAULT |=> rdData == {15'h0000, $past(faultActive)})
        else $error("fault input mismatch");

    // references outside the map are flagged and read zero
    chk_unmapped_read: assert property (
        rdEn && !isMapped(rdAddr) |=> rdError && rdValid && rdData == 16'h0000)
        else $error("unmapped read not flagged");

    // every request gets its answer strobe one cycle later
    chk_answer_once: assert property (
        rdEn |=> rdValid)
        else $error("read not answered");

    // no request leaves the answer side quiet
    chk_idle_quiet: assert property (
        !rdEn |=> !rdValid && !rdError && rdData == 16'h0000)
        else $error("answer without request");

    cov_scale_read:  cover property (rdEn && rdAddr == gds_pkg::ADDR_SCALE_ONE
                                     ##2 rdEn && rdAddr == gds_pkg::ADDR_SCALE_TWO);
    cov_toggle_seen: cover property (tick2s ##1 liveToggle);
    cov_fault_read:  cover property (rdEn && rdAddr == gds_pkg::ADDR_STATE_TWO && flowErr);
    cov_unmapped:    cover property (rdEn && !isMapped(rdAddr));
endmodule : gds_status_map

// >>> verification/gds_master_model.sv
// gds_master_model: polling master that issues single reads on the register port
`timescale 1ns/1ps
module gds_master_model (
    // clock
    input  wire logic        ref_clk,
    // read request side
    output logic             rdEn,
    output logic      [15:0] rdAddr,
    // read answer side
    input  wire logic [15:0] rdData,
    input  wire logic        rdValid,
    input  wire logic        rdError
);
    initial begin
        rdEn   = 1'b0;
        rdAddr = 16'h0000;
    end

    // one read: request for one cycle, answer taken one cycle later
    task automatic read(input logic [15:0] a, output logic [15:0] d, output logic e,
                        output logic v);
        @(negedge ref_clk);
        rdEn   = 1'b1;
        rdAddr = a;
        @(negedge ref_clk);
        // a released address shows a stale inverse, never the last value
        rdEn   = 1'b0;
        rdAddr = ~a;
        d      = rdData;
        e      = rdError;
        v      = rdValid;
    endtask : read
endmodule : gds_master_model

// >>> verification/testbench.sv
// testbench: self-checking bench for the detector status map
`timescale 1ns/1ps
module testbench;
    localparam int TP = 8;    // shortened toggle period
    logic        ref_clk;     // 250 MHz clock
    logic        nrst;        // active-low reset
    logic [15:0] st;          // conditions by state-two bit; bit6 feeds the menu input
    logic [31:0] fullScale;   // full-scale setting
    logic        rdEn;        // read request
    logic [15:0] rdAddr;      // read reference
    logic [15:0] rdData;      // read data
    logic        rdValid;     // answer strobe
    logic        rdError;     // unmapped flag
    logic        liveToggle;  // liveness bit
    int          mismatches;  // failed comparisons
    int          n_tests;     // comparisons made

    gds_status_map #(.TOGGLE_PERIOD(TP)) i_gds_status_map (
        .ref_clk(ref_clk), .nrst(nrst), .alarmOne(st[0]), .alarmTwo(st[1]),
        .faultActive(st[2]), .maintActive(st[3]), .testActive(st[4]), .calActive(st[5]),
        .menuEntered(st[6]), .cartridgeErr(st[7]), .flowErr(st[8]), .commErr(st[9]),
        .pyroErr(st[10]), .fullScale(fullScale), .rdEn(rdEn), .rdAddr(rdAddr),
        .rdData(rdData), .rdValid(rdValid), .rdError(rdError), .liveToggle(liveToggle));

    gds_master_model i_gds_master_model (
        .ref_clk(ref_clk), .rdEn(rdEn), .rdAddr(rdAddr), .rdData(rdData),
        .rdValid(rdValid), .rdError(rdError));

    // clock generator
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string m);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk16

    task automatic chk1(input logic got, input logic exp, input string m);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t %s got %b exp %b", $time, m, got, exp);
        end
    endtask : chk1

    // read through the master model; every read must be answered
    task automatic rd(input logic [15:0] a, output logic [15:0] d, output logic e);
        logic v;
        i_gds_master_model.read(a, d, e, v);
        chk1(v, 1'b1, "no answer strobe");
    endtask : rd

    // one condition at a time; only its own discrete input may read 1
    task automatic test_discrete();
        int          sel [7] = '{0, 1, 2, 6, 4, 5, 3};
        int          map [7] = '{0, 1, 2, 6, 4, 5, 15};
        logic [15:0] d;
        logic        e;
        for (int s = 0; s < 7; s++) begin
            st = 16'h0001 << sel[s];
            for (int j = 0; j < 7; j++) begin
                rd(16'h2711 + 16'(j), d, e);
                chk16(d, {15'h0000, map[j] == sel[s]}, "discrete input");
                chk1(e, 1'b0, "discrete flag");
            end
        end
    endtask : test_discrete

    // fault bits alone and all together; reserved bits stay clear
    task automatic test_state_two();
        logic [15:0] p [5] = '{16'h0100, 16'h0200, 16'h0400, 16'h0007, 16'hffff};
        logic [15:0] d;
        logic        e;
        for (int k = 0; k < 5; k++) begin
            st = p[k];
            rd(gds_pkg::ADDR_STATE_TWO, d, e);
            chk16(d, p[k] & 16'h07bf, "state two");
        end
    endtask : test_state_two

    // both words of the full-scale value
    task automatic test_full_scale();
        logic [15:0] d;
        logic        e;
        fullScale = 32'h4479c000;
        rd(gds_pkg::ADDR_SCALE_ONE, d, e);
        chk16(d, 16'h4479, "scale word one");
        rd(gds_pkg::ADDR_SCALE_TWO, d, e);
        chk16(d, 16'hc000, "scale word two");
    endtask : test_full_scale

    // references next to the map are flagged and read zero
    task automatic test_unmapped();
        logic [15:0] a [4] = '{16'h2710, 16'h2719, 16'h9c52, 16'h9c56};
        logic [15:0] d;
        logic        e;
        for (int k = 0; k < 4; k++) begin
            rd(a[k], d, e);
            chk1(e, 1'b1, "unmapped flag");
            chk16(d, 16'h0000, "unmapped data");
        end
    endtask : test_unmapped

    // time between inversions, then the bit as read at its reference
    task automatic test_toggle();
        logic [15:0] d;
        logic        e;
        logic        lv;
        int          n;
        for (int r = 0; r < 2; r++) begin
            lv = liveToggle;
            n  = 0;
            while (liveToggle === lv && n < 4 * TP) begin
                @(negedge ref_clk);
                n++;
            end
        end
        chk16(16'(n), 16'(TP), "toggle period");
        // read once in each phase so both levels are seen at the reference
        for (int r = 0; r < 2; r++) begin
            lv = liveToggle;
            rd(gds_pkg::ADDR_TOGGLE, d, e);
            chk16(d, {15'h0000, lv}, "toggle input");
            repeat (TP) @(negedge ref_clk);
        end
    endtask : test_toggle

    // mid-run reset: a read gets no answer, the liveness count restarts
    task automatic test_reset();
        logic [15:0] d;
        logic        e;
        logic        v;
        int          n;
        st = 16'h0001;
        n  = 0;
        while (liveToggle !== 1'b1 && n < 4 * TP) begin
            @(negedge ref_clk);
            n++;
        end
        nrst = 1'b0;
        i_gds_master_model.read(gds_pkg::ADDR_ALARM_ONE, d, e, v);
        chk1(v, 1'b0, "answer during reset");
        chk1(e, 1'b0, "flag during reset");
        chk16(d, gds_pkg::RST_READ_DATA, "data during reset");
        chk1(liveToggle, gds_pkg::RST_TOGGLE, "toggle during reset");
        nrst = 1'b1;
        n    = 0;
        while (liveToggle === gds_pkg::RST_TOGGLE && n < 4 * TP) begin
            @(negedge ref_clk);
            n++;
        end
        chk16(16'(n), 16'(TP + 1), "first toggle after reset");
    endtask : test_reset

    task automatic give_verdict();
        $display("tests %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : give_verdict

    // main sequence
    initial begin
        mismatches = 0;
        n_tests    = 0;
        nrst       = 1'b0;
        st         = 16'h0000;
        fullScale  = 32'h00000000;
        repeat (10) @(negedge ref_clk);
        nrst = 1'b1;
        test_discrete();
        test_state_two();
        test_full_scale();
        test_unmapped();
        test_toggle();
        test_reset();
        give_verdict();
    end

    // watchdog, well beyond the 63 reads above
    initial begin
        #40000;
        mismatches++;
        give_verdict();
    end
endmodule : testbench
